/* File: include/fpc_consts.vh */
// Constants for the floating-point compare unit
`ifndef FPC_CONSTS_VH
`define FPC_CONSTS_VH

// Compare operation codes
`define FPC_OP_EQ       2'h0
`define FPC_OP_GT       2'h1
`define FPC_OP_LT       2'h2

// Single-precision field layout
`define FPC_SP_SIGN     31
`define FPC_SP_EXP_HI   30
`define FPC_SP_EXP_LO   23
`define FPC_SP_MAN_HI   22
// Double-precision high-word field layout
`define FPC_DP_SIGN     31
`define FPC_DP_EXP_HI   30
`define FPC_DP_EXP_LO   20
`define FPC_DP_MAN_HI   19

// Result words
`define FPC_TRUE        32'h00000001
`define FPC_FALSE       32'h00000000

// Reset values
`define FPC_RST_WORD    32'h00000000
`define FPC_RST_FLAG    1'h0

// Double-precision sequence states
`define FPC_ST_IDLE     1'h0
`define FPC_ST_HIGH     1'h1

`endif

/* File: rtl/fpc_classify.v */
// Operand classifier: NaN, infinity, zero-or-denormal and denormal
`timescale 1ns/1ps
module fpc_classify #(
   parameter EXP_W = 8,
   parameter MAN_W = 23
) (
   // Operand
   input  wire [EXP_W+MAN_W:0] value,
   // Class outputs
   output wire                 is_nan,
   output wire                 is_inf,
   output wire                 is_zero,
   output wire                 is_denorm
);

   wire exp_ones;
   wire exp_zero;
   wire man_zero;

   assign exp_ones  = &value[EXP_W+MAN_W-1:MAN_W];
   assign exp_zero  = ~|value[EXP_W+MAN_W-1:MAN_W];
   assign man_zero  = ~|value[MAN_W-1:0];
   assign is_nan    = exp_ones & ~man_zero;
   assign is_inf    = exp_ones & man_zero;
   // Denormals count as zero of either sign
   assign is_zero   = exp_zero;
   assign is_denorm = exp_zero & ~man_zero;

endmodule

/* File: rtl/fpc_compare_unit.v */
// Floating-point compare datapath, single and double precision
`timescale 1ns/1ps
`include "fpc_consts.vh"
module fpc_compare_unit #(
   parameter DST_W = 5
) (
   // Clock and reset
   input  wire             clk,
   input  wire             rstn,
   // Issue
   input  wire             issue_valid,
   input  wire             cond_true,
   input  wire             is_double,
   input  wire [1:0]       cmp_op,
   input  wire [DST_W-1:0] dst_sel,
   // Source words
   input  wire [31:0]      src1_word,
   input  wire [31:0]      src2_word,
   // Result write
   output reg              wr_en_ff,
   output reg  [DST_W-1:0] wr_dst_ff,
   output reg  [31:0]      wr_data_ff,
   // Status
   output wire             busy,
   output reg              unordered_flag_ff,
   output reg              invalid_op_flag_ff,
   output reg              nan_seen_flag1_ff,
   output reg              nan_seen_flag2_ff,
   output reg              denormal_seen_flag1_ff,
   output reg              denormal_seen_flag2_ff
);

   ////////////////////////////////////////////////////////////////////////////
   // Double-precision sequence state
   reg             state_ff;
   reg             nxt_state;
   reg [31:0]      lo1_ff;
   reg [31:0]      lo2_ff;
   reg [1:0]       op_ff;
   reg [DST_W-1:0] dst_ff;

   assign busy = (state_ff == `FPC_ST_HIGH);

   // A false predicate never starts work
   wire take_sp = issue_valid & cond_true & ~is_double & ~busy;
   wire take_dp = issue_valid & cond_true & is_double & ~busy;
   wire fin_dp  = busy;

   ////////////////////////////////////////////////////////////////////////////
   // Operand assembly
   wire [63:0] d1 = {src1_word, lo1_ff};
   wire [63:0] d2 = {src2_word, lo2_ff};
   wire [1:0]  op = fin_dp ? op_ff : cmp_op;

   ////////////////////////////////////////////////////////////////////////////
   // Classification, one lane per source
   wire [1:0] nan_v;
   wire [1:0] inf_v;
   wire [1:0] zer_v;
   wire [1:0] den_v;

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_src
         wire [31:0] sw = (gi == 0) ? src1_word : src2_word;
         wire [63:0] dw = (gi == 0) ? d1 : d2;
         wire        s_nan;
         wire        s_inf;
         wire        s_zer;
         wire        s_den;
         wire        d_nan;
         wire        d_inf;
         wire        d_zer;
         wire        d_den;

         fpc_classify #(.EXP_W(8), .MAN_W(23)) u_sp (
            .value     (sw),
            .is_nan    (s_nan),
            .is_inf    (s_inf),
            .is_zero   (s_zer),
            .is_denorm (s_den)
         );
         fpc_classify #(.EXP_W(11), .MAN_W(52)) u_dp (
            .value     (dw),
            .is_nan    (d_nan),
            .is_inf    (d_inf),
            .is_zero   (d_zer),
            .is_denorm (d_den)
         );

         // Double classes only mean something once the high words are on the bus
         assign nan_v[gi] = fin_dp ? d_nan : s_nan;
         assign inf_v[gi] = fin_dp ? d_inf : s_inf;
         assign zer_v[gi] = fin_dp ? d_zer : s_zer;
         assign den_v[gi] = fin_dp ? d_den : s_den;
      end
   endgenerate

   wire nan1 = nan_v[0];
   wire nan2 = nan_v[1];
   wire zer1 = zer_v[0];
   wire zer2 = zer_v[1];
   wire den1 = den_v[0];
   wire den2 = den_v[1];
   wire inf1 = inf_v[0];
   wire inf2 = inf_v[1];

   ////////////////////////////////////////////////////////////////////////////
   // Sign and magnitude fields
   wire        sg1     = src1_word[`FPC_SP_SIGN];
   wire        sg2     = src2_word[`FPC_SP_SIGN];
   wire [30:0] sp_mag1 = src1_word[`FPC_SP_EXP_HI:0];
   wire [30:0] sp_mag2 = src2_word[`FPC_SP_EXP_HI:0];
   wire [62:0] dp_mag1 = d1[62:0];
   wire [62:0] dp_mag2 = d2[62:0];
   // Single words sit at the top so one comparator serves both widths
   wire [62:0] m1      = fin_dp ? dp_mag1 : {sp_mag1, 32'h00000000};
   wire [62:0] m2      = fin_dp ? dp_mag2 : {sp_mag2, 32'h00000000};
   wire        mag_gt  = (m1 > m2);
   wire        mag_lt  = (m1 < m2);
   wire        mag_eq  = (m1 == m2);
   wire        unordered_flag   = nan1 | nan2;

   ////////////////////////////////////////////////////////////////////////////
   // Operation decode
   wire op_ord = (op == `FPC_OP_GT) | (op == `FPC_OP_LT);

   ////////////////////////////////////////////////////////////////////////////
   // Operand classes
   localparam CL_NAN  = 3'h0;
   localparam CL_ZERO = 3'h1;
   localparam CL_PINF = 3'h2;
   localparam CL_NINF = 3'h3;
   localparam CL_PFIN = 3'h4;
   localparam CL_NFIN = 3'h5;

   reg [2:0] cls1;
   reg [2:0] cls2;
   // Denormals fold into zero before any ordering is decided
   always @* begin
      if (nan1) begin
         cls1 = CL_NAN;
      end else if (zer1) begin
         cls1 = CL_ZERO;
      end else if (inf1) begin
         cls1 = sg1 ? CL_NINF : CL_PINF;
      end else begin
         cls1 = sg1 ? CL_NFIN : CL_PFIN;
      end
   end

   always @* begin
      if (nan2) begin
         cls2 = CL_NAN;
      end else if (zer2) begin
         cls2 = CL_ZERO;
      end else if (inf2) begin
         cls2 = sg2 ? CL_NINF : CL_PINF;
      end else begin
         cls2 = sg2 ? CL_NFIN : CL_PFIN;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Ordering decision
   reg eq_r;
   reg gt_r;
   reg lt_r;
   always @* begin
      eq_r = 1'b0;
      gt_r = 1'b0;
      lt_r = 1'b0;
      if ((cls1 == CL_NAN) | (cls2 == CL_NAN)) begin
         // No order exists, every test answers 0
         eq_r = 1'b0;
      end else if ((cls1 == CL_ZERO) & (cls2 == CL_ZERO)) begin
         eq_r = 1'b1;
      end else if (cls1 == CL_PINF) begin
         eq_r = (cls2 == CL_PINF);
         gt_r = (cls2 != CL_PINF);
      end else if (cls1 == CL_NINF) begin
         eq_r = (cls2 == CL_NINF);
         lt_r = (cls2 != CL_NINF);
      end else if (cls2 == CL_PINF) begin
         lt_r = 1'b1;
      end else if (cls2 == CL_NINF) begin
         gt_r = 1'b1;
      end else if (cls1 == CL_ZERO) begin
         // Zero against a finite value follows that value's sign
         gt_r = sg2;
         lt_r = ~sg2;
      end else if (cls2 == CL_ZERO) begin
         gt_r = ~sg1;
         lt_r = sg1;
      end else if (sg1 != sg2) begin
         gt_r = ~sg1;
         lt_r = sg1;
      end else begin
         eq_r = mag_eq;
         gt_r = sg1 ? mag_lt : mag_gt;
         lt_r = sg1 ? mag_gt : mag_lt;
      end
   end

   reg res_bit;
   always @* begin
      case (op)
         `FPC_OP_EQ: res_bit = eq_r;
         `FPC_OP_GT: res_bit = gt_r;
         `FPC_OP_LT: res_bit = lt_r;
         default:    res_bit = 1'b0;
      endcase
   end

   wire finish = take_sp | fin_dp;

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer
   always @* begin
      case (state_ff)
         `FPC_ST_IDLE: nxt_state = take_dp ? `FPC_ST_HIGH : `FPC_ST_IDLE;
         `FPC_ST_HIGH: nxt_state = `FPC_ST_IDLE;
         default:      nxt_state = `FPC_ST_IDLE;
      endcase
   end

   always @(posedge clk) begin
      if (!rstn) begin
         state_ff <= `FPC_ST_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Low words and the destination wait here for the high-word cycle
   always @(posedge clk) begin
      if (!rstn) begin
         lo1_ff <= `FPC_RST_WORD;
         lo2_ff <= `FPC_RST_WORD;
         op_ff  <= `FPC_OP_EQ;
         dst_ff <= {DST_W{1'b0}};
      end else if (take_dp) begin
         lo1_ff <= src1_word;
         lo2_ff <= src2_word;
         op_ff  <= cmp_op;
         dst_ff <= dst_sel;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Result write
   always @(posedge clk) begin
      if (!rstn) begin
         wr_en_ff   <= 1'b0;
         wr_dst_ff  <= {DST_W{1'b0}};
         wr_data_ff <= `FPC_RST_WORD;
      end else begin
         wr_en_ff <= finish;
         if (finish) begin
            wr_dst_ff  <= fin_dp ? dst_ff : dst_sel;
            wr_data_ff <= res_bit ? `FPC_TRUE : `FPC_FALSE;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Status flags, refreshed only by executed compares
   always @(posedge clk) begin
      if (!rstn) begin
         unordered_flag_ff      <= `FPC_RST_FLAG;
         invalid_op_flag_ff     <= `FPC_RST_FLAG;
         nan_seen_flag1_ff      <= `FPC_RST_FLAG;
         nan_seen_flag2_ff      <= `FPC_RST_FLAG;
         denormal_seen_flag1_ff <= `FPC_RST_FLAG;
         denormal_seen_flag2_ff <= `FPC_RST_FLAG;
      end else if (finish) begin
         unordered_flag_ff      <= unordered_flag;
         invalid_op_flag_ff     <= unordered_flag & op_ord;
         nan_seen_flag1_ff      <= nan1;
         nan_seen_flag2_ff      <= nan2;
         denormal_seen_flag1_ff <= den1;
         denormal_seen_flag2_ff <= den2;
      end
   end

endmodule

/* File: verif/fpc_cmp_monitor.sv */
// Checker for the floating-point compare unit
`timescale 1ns/1ps
`include "fpc_consts.vh"
module fpc_cmp_monitor #(parameter DST_W = 5) (
   // Clock, reset and issue
   input wire logic             clk,
   input wire logic             rstn,
   input wire logic             issue_valid,
   input wire logic             cond_true,
   input wire logic             is_double,
   input wire logic [1:0]       cmp_op,
   input wire logic [DST_W-1:0] dst_sel,
   // Result and status
   input wire logic             wr_en_ff,
   input wire logic             busy,
   input wire logic             unordered_flag_ff,
   input wire logic             invalid_op_flag_ff,
   input wire logic             nan_seen_flag1_ff,
   input wire logic             nan_seen_flag2_ff,
   input wire logic [DST_W-1:0] wr_dst_ff,
   input wire logic [31:0]      wr_data_ff
);
   wire take = issue_valid && cond_true && !busy;
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   property p_sp_lat; take && !is_double |=> wr_en_ff && wr_dst_ff == $past(dst_sel); endproperty
   a_sp_lat: assert property (p_sp_lat) else $error("single result late");
   property p_dp_lat; take && is_double |=> busy && !wr_en_ff ##1 wr_en_ff && !busy; endproperty
   a_dp_lat: assert property (p_dp_lat) else $error("double sequence wrong");
   property p_word; wr_en_ff |-> wr_data_ff[31:1] == 31'h0; endproperty
   a_word: assert property (p_word) else $error("result not 0 or 1");
   property p_nop; !take && !busy |=> !wr_en_ff && $stable(wr_data_ff) && $stable(unordered_flag_ff); endproperty
   a_nop: assert property (p_nop) else $error("output moved without issue");
   property p_nan; wr_en_ff && unordered_flag_ff |-> wr_data_ff == `FPC_FALSE; endproperty
   a_nan: assert property (p_nan) else $error("unordered result not 0");
   property p_inv; invalid_op_flag_ff |-> unordered_flag_ff; endproperty
   a_inv: assert property (p_inv) else $error("invalid without unordered");
   property p_eq_inv; take && !is_double && cmp_op == `FPC_OP_EQ |=> !invalid_op_flag_ff; endproperty
   a_eq_inv: assert property (p_eq_inv) else $error("equal set invalid");
   property p_unordered_flag; wr_en_ff |-> unordered_flag_ff == (nan_seen_flag1_ff || nan_seen_flag2_ff); endproperty
   a_unordered_flag: assert property (p_unordered_flag) else $error("unordered and NaN seen differ");
   c_sp: cover property (take && !is_double);
   c_dp: cover property (take && is_double);
   c_nan: cover property (wr_en_ff && unordered_flag_ff);
endmodule
bind fpc_compare_unit fpc_cmp_monitor #(.DST_W(DST_W)) mon_u (.*);

/* File: verif/fpc_rf_model.sv */
// Register file model collecting compare results
`timescale 1ns/1ps
module fpc_rf_model #(parameter DST_W = 5) (
   // Clock, write side and read select
   input wire logic             clk, wr_en,
   input wire logic [DST_W-1:0] wr_dst, rd_sel,
   input wire logic [31:0]      wr_data,
   // Read side
   output logic     [31:0]      rd_data
);
   logic [31:0] rf [0:(1<<DST_W)-1];
   initial for (int i = 0; i < (1<<DST_W); i++) rf[i] = 32'h5A5A5A5A;
   always @(posedge clk) if (wr_en) rf[wr_dst] <= wr_data;
   assign rd_data = rf[rd_sel];
endmodule

/* File: verif/fp_compare_unit_tb.sv */
// Self-checking bench for the floating-point compare unit
`timescale 1ns/1ps
`include "fpc_consts.vh"
module fp_compare_unit_tb;
   localparam [63:0] ONE = 64'h3F800000, TWO = 64'h40000000, MON = 64'hBF800000, PIN = 64'h7F800000;
   localparam [63:0] NIN = 64'hFF800000, QNN = 64'h7FC00000, DEN = 64'h1, NZR = 64'h80000000;
   localparam [63:0] DON = 64'h3FF0000000000000, DQN = 64'h7FF8000000000000;
   logic        clk = 0, rstn = 0, issue_valid = 0, cond_true = 0, is_double = 0;
   logic [1:0]  cmp_op = 0;
   logic [4:0]  dst_sel = 0, rd_sel = 0, dn = 0;
   logic [31:0] src1_word = 0, src2_word = 0;
   logic [5:0]  fprev = 0;
   wire         wr_en_ff, busy, unordered_flag_ff, invalid_op_flag_ff, nan_seen_flag1_ff, nan_seen_flag2_ff;
   wire         denormal_seen_flag1_ff, denormal_seen_flag2_ff;
   wire  [4:0]  wr_dst_ff;
   wire  [31:0] wr_data_ff, rd_data;
   wire  [5:0]  flg = {unordered_flag_ff, invalid_op_flag_ff, nan_seen_flag1_ff, nan_seen_flag2_ff,
                       denormal_seen_flag1_ff, denormal_seen_flag2_ff};
   int          fail_count = 0, n_tests = 0;
   always #12.5 clk = ~clk;
   fpc_compare_unit #(.DST_W(5)) dut_u (
      .clk(clk), .rstn(rstn), .issue_valid(issue_valid), .cond_true(cond_true), .is_double(is_double),
      .cmp_op(cmp_op), .dst_sel(dst_sel), .src1_word(src1_word), .src2_word(src2_word),
      .wr_en_ff(wr_en_ff), .wr_dst_ff(wr_dst_ff), .wr_data_ff(wr_data_ff), .busy(busy),
      .unordered_flag_ff(unordered_flag_ff), .invalid_op_flag_ff(invalid_op_flag_ff),
      .nan_seen_flag1_ff(nan_seen_flag1_ff), .nan_seen_flag2_ff(nan_seen_flag2_ff),
      .denormal_seen_flag1_ff(denormal_seen_flag1_ff), .denormal_seen_flag2_ff(denormal_seen_flag2_ff));
   fpc_rf_model #(.DST_W(5)) rf_u (.clk(clk), .wr_en(wr_en_ff), .wr_dst(wr_dst_ff), .rd_sel(rd_sel),
                                   .wr_data(wr_data_ff), .rd_data(rd_data));
   ////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, exp);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // One compare, then flags, then the stored word
   task automatic t(input logic d, c, input logic [1:0] op, input logic [63:0] a, b, input logic e,
                    input logic [5:0] f);
      @(posedge clk);
      issue_valid <= 1;
      cond_true <= c;
      is_double <= d;
      cmp_op <= op;
      dst_sel <= dn;
      src1_word <= a[31:0];
      src2_word <= b[31:0];
      @(posedge clk);
      if (d) begin
         src1_word <= a[63:32];
         src2_word <= b[63:32];
         @(posedge clk);
      end
      issue_valid <= 0;
      #1;
      chk({31'h0, wr_en_ff}, {31'h0, c});
      if (c) fprev = f;
      chk({26'h0, flg}, {26'h0, fprev});
      rd_sel = dn;
      @(posedge clk);
      #1;
      chk(rd_data, c ? {31'h0, e} : 32'h5A5A5A5A);
      dn++;
   endtask
   ////////////////////////////////////////////////////////////
   task sc_order;
      t(0, 1, `FPC_OP_EQ, ONE, ONE, 1, 6'h0);
      t(0, 1, `FPC_OP_EQ, ONE, TWO, 0, 6'h0);
      t(0, 1, `FPC_OP_GT, TWO, ONE, 1, 6'h0);
      t(0, 1, `FPC_OP_GT, ONE, TWO, 0, 6'h0);
      t(0, 1, `FPC_OP_LT, MON, ONE, 1, 6'h0);
      t(0, 1, `FPC_OP_LT, ONE, MON, 0, 6'h0);
      t(0, 1, 2'h3, ONE, ONE, 0, 6'h0);
   endtask
   task sc_nan_zero;
      t(0, 1, `FPC_OP_EQ, QNN, QNN, 0, 6'h2C);
      t(0, 1, `FPC_OP_GT, ONE, QNN, 0, 6'h34);
      t(0, 1, `FPC_OP_LT, QNN, ONE, 0, 6'h38);
      t(0, 1, `FPC_OP_EQ, DEN, NZR, 1, 6'h02);
      t(0, 1, `FPC_OP_GT, DEN, NZR | DEN, 0, 6'h03);
      t(0, 1, `FPC_OP_LT, NZR | DEN, DEN, 0, 6'h03);
   endtask
   task sc_inf;
      t(0, 1, `FPC_OP_EQ, PIN, PIN, 1, 6'h0);
      t(0, 1, `FPC_OP_EQ, NIN, PIN, 0, 6'h0);
      t(0, 1, `FPC_OP_GT, PIN, TWO, 1, 6'h0);
      t(0, 1, `FPC_OP_GT, NIN, NIN, 0, 6'h0);
      t(0, 1, `FPC_OP_LT, NIN, ONE, 1, 6'h0);
      t(0, 1, `FPC_OP_LT, PIN, PIN, 0, 6'h0);
   endtask
   task sc_double;
      t(1, 1, `FPC_OP_EQ, DON, DON, 1, 6'h0);
      t(1, 1, `FPC_OP_GT, DON | DEN, DON, 1, 6'h0);
      t(1, 1, `FPC_OP_LT, DQN, DON, 0, 6'h38);
   endtask
   task sc_nop;
      t(0, 0, `FPC_OP_GT, TWO, ONE, 1, 6'h0);
      t(1, 0, `FPC_OP_EQ, DON, DON, 1, 6'h0);
   endtask
   ////////////////////////////////////////////////////////////
   task close_out;
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // About 24 compares of at most 4 cycles each
   initial begin
      repeat (400) @(posedge clk);
      fail_count++;
      close_out;
   end
   initial begin
      repeat (10) @(posedge clk);
      rstn <= 1;
      sc_order;
      sc_nan_zero;
      sc_inf;
      sc_double;
      sc_nop;
      close_out;
   end
endmodule
